// ### core/drt_pkg.sv
/*
 * drt_pkg: constants and bus carriers for the debug rom table tail.
 * assumes an apb slave port with 32-bit data and byte addresses.
 */
package drt_pkg;

    // =====================================================================
    // bus widths
    // =====================================================================
    localparam int ADDR_W = 13;
    localparam int DATA_W = 32;

    // =====================================================================
    // register byte offsets
    // =====================================================================
    localparam logic [ADDR_W-1:0] OFF_ROM_ENTRY_WORD = 13'h1004;
    localparam logic [ADDR_W-1:0] OFF_ROM_TABLE_END_MARKER = 13'h1008;
    localparam logic [ADDR_W-1:0] OFF_ROM_MEMORY_TYPE = 13'h1fcc;
    localparam logic [ADDR_W-1:0] OFF_PERIPHERAL_IDENT_WORD4 = 13'h1fd0;

    // =====================================================================
    // field positions
    // =====================================================================
    localparam int COMPONENT_OFFSET_LSB = 12;
    localparam int COMPONENT_OFFSET_W = 20;
    localparam int ENTRY_FORMAT_BIT_POS = 1;
    localparam int ENTRY_PRESENT_FLAG_POS = 0;
    localparam int SYSMEM_PRESENT_FLAG_POS = 0;
    localparam int BLOCK_COUNT_FIELD_LSB = 4;
    localparam int CONTINUATION_CODE_FIELD_LSB = 0;
    localparam int ID_FIELD_W = 4;

    // =====================================================================
    // fixed and reset values
    // =====================================================================
    localparam logic [DATA_W-1:0] END_MARKER_VALUE = 32'h0000_0000;
    localparam logic [DATA_W-1:0] PERIPHERAL_IDENT_WORD4_VALUE = 32'h0000_0000;
    localparam logic ENTRY_FORMAT_BIT_VALUE = 1'h1;
    localparam logic [ID_FIELD_W-1:0] BLOCK_COUNT_VALUE = 4'h0;
    localparam logic [ID_FIELD_W-1:0] CONTINUATION_CODE_VALUE = 4'h0;
    // safe values held until the protection state has been caught
    localparam logic ENTRY_PRESENT_FLAG_RST = 1'h1;
    localparam logic SYSMEM_PRESENT_FLAG_RST = 1'h0;
    localparam logic [COMPONENT_OFFSET_W-1:0] COMPONENT_OFFSET_DEFAULT = 20'h00001;

    // =====================================================================
    // apb carriers
    // =====================================================================
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } drt_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } drt_apb_rsp_t;

endpackage

// ### core/drt_rom_tail.sv
/*
 * drt_rom_tail: read-only apb register bank at the tail of a debug rom
 * table (one entry word, end marker, memory type, peripheral id word 4).
 * assumes i_protected comes from protection logic on i_ref_clk and is
 * settled when reset is released.
 */
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// [R01] entry word bits 31:12 return component base offset relative to table base
// [R02] entry format bit always reads one, marking 32-bit entries
// [R03] entry present flag latched at power-up; one means no entry here
// [R04] end marker word reads all zeros, no entries follow
// [R05] unprotected at power-up: system memory present flag set
// [R06] protected at power-up: system memory present flag cleared
// [R07] block count field of id word four always reads zero
// [R08] id word four sits at its offset and reads all zeros
// [R09] continuation code field of id word four always reads zero
// [R10] all words read-only; writes ignored, values constant or power-up latched
module drt_rom_tail #(
    parameter logic [drt_pkg::COMPONENT_OFFSET_W-1:0] COMPONENT_OFFSET =
        drt_pkg::COMPONENT_OFFSET_DEFAULT
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // protection state from the security logic
    input wire logic i_protected,
    // apb slave
    input wire drt_pkg::drt_apb_req_t i_apb,
    output drt_pkg::drt_apb_rsp_t o_apb
);

    // =====================================================================
    // address decode
    // =====================================================================
    // word match only; byte lanes below bit 2 are ignored
    function automatic logic drt_hit(input logic [drt_pkg::ADDR_W-1:0] addr,
                                     input logic [drt_pkg::ADDR_W-1:0] off);
        drt_hit = (addr[drt_pkg::ADDR_W-1:2] == off[drt_pkg::ADDR_W-1:2]);
    endfunction

    wire logic hit_entry;
    wire logic hit_end;
    wire logic hit_rom_memory_type;
    wire logic hit_peripheral_ident_word4;
    wire logic hit_any;
    wire logic setup_phase;
    wire logic access_done;

    assign hit_entry = drt_hit(i_apb.paddr, drt_pkg::OFF_ROM_ENTRY_WORD);
    assign hit_end = drt_hit(i_apb.paddr, drt_pkg::OFF_ROM_TABLE_END_MARKER);
    assign hit_rom_memory_type = drt_hit(i_apb.paddr, drt_pkg::OFF_ROM_MEMORY_TYPE);
    assign hit_peripheral_ident_word4 = drt_hit(i_apb.paddr, drt_pkg::OFF_PERIPHERAL_IDENT_WORD4);
    assign hit_any = hit_entry | hit_end | hit_rom_memory_type | hit_peripheral_ident_word4;
    assign setup_phase = i_apb.psel & ~i_apb.penable;
    assign access_done = i_apb.psel & i_apb.penable & o_apb.pready;

    // =====================================================================
    // power-up latch of the protection state
    // =====================================================================
    logic captured;
    logic entry_present_flag;
    logic sysmem_present_flag;

    // caught on the first edge after reset release, then frozen until the
    // next reset; writes never reach these, so a debugger cannot unlock
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            captured <= 1'h0;
            entry_present_flag <= drt_pkg::ENTRY_PRESENT_FLAG_RST;
            sysmem_present_flag <= drt_pkg::SYSMEM_PRESENT_FLAG_RST;
        end else if (!captured) begin
            captured <= 1'h1;
            entry_present_flag <= i_protected; // see [R03]
            sysmem_present_flag <= ~i_protected; // see [R05] see [R06]
        end
    end

    // =====================================================================
    // register words
    // =====================================================================
    wire logic [drt_pkg::DATA_W-1:0] word_entry;
    wire logic [drt_pkg::DATA_W-1:0] word_rom_memory_type;
    wire logic [drt_pkg::DATA_W-1:0] word_peripheral_ident_word4;
    wire logic [drt_pkg::DATA_W-1:0] next_rdata;

    assign word_entry = {COMPONENT_OFFSET, // see [R01]
                         10'h000,
                         drt_pkg::ENTRY_FORMAT_BIT_VALUE, // see [R02]
                         entry_present_flag};
    assign word_rom_memory_type = {31'h0000_0000, sysmem_present_flag};
    assign word_peripheral_ident_word4 = drt_pkg::PERIPHERAL_IDENT_WORD4_VALUE // see [R08]
                     | {24'h00_0000,
                        drt_pkg::BLOCK_COUNT_VALUE, // see [R07]
                        drt_pkg::CONTINUATION_CODE_VALUE}; // see [R09]

    assign next_rdata = hit_entry ? word_entry :
                        hit_rom_memory_type ? word_rom_memory_type :
                        hit_peripheral_ident_word4 ? word_peripheral_ident_word4 :
                        drt_pkg::END_MARKER_VALUE; // see [R04]

    // =====================================================================
    // apb response
    // =====================================================================
    // answer is prepared at the setup edge so pready is high in the first
    // access cycle; writes only get the handshake and store nothing
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_apb <= '0;
        end else begin
            o_apb.pready <= setup_phase;
            o_apb.pslverr <= setup_phase & ~hit_any;
            o_apb.prdata <= (setup_phase & ~i_apb.pwrite) ? next_rdata : '0; // see [R10]
        end
    end

    // =====================================================================
    // checks
    // =====================================================================
    wire logic rd_done;
    assign rd_done = access_done & ~i_apb.pwrite;

    property p_entry_offset;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        rd_done && hit_entry |-> o_apb.prdata[31:12] == COMPONENT_OFFSET;
    endproperty
    a_entry_offset: assert property (p_entry_offset) // see [R01]
        else $error("entry word offset field wrong");

    property p_entry_format;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        rd_done && hit_entry |-> o_apb.prdata[1] && o_apb.prdata[11:2] == 10'h000;
    endproperty
    a_entry_format: assert property (p_entry_format) // see [R02]
        else $error("entry format bit not one");

    property p_entry_latch;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        $rose(captured) |-> entry_present_flag == $past(i_protected);
    endproperty
    a_entry_latch: assert property (p_entry_latch) // see [R03]
        else $error("entry present flag not latched from protection");

    property p_end_zero;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        rd_done && hit_end |-> o_apb.prdata == 32'h0000_0000 && !o_apb.pslverr;
    endproperty
    a_end_zero: assert property (p_end_zero) // see [R04]
        else $error("end marker not zero");

    property p_sysmem_unprot;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        $rose(captured) && !$past(i_protected) |-> sysmem_present_flag;
    endproperty
    a_sysmem_unprot: assert property (p_sysmem_unprot) // see [R05]
        else $error("sysmem flag clear while unprotected");

    property p_sysmem_prot;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        captured && !$past(sysmem_present_flag) && rd_done && hit_rom_memory_type
            |-> o_apb.prdata == 32'h0000_0000;
    endproperty
    a_sysmem_prot: assert property (p_sysmem_prot) // see [R06]
        else $error("memory type reads set while protected");

    property p_peripheral_ident_word4_fields;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        rd_done && hit_peripheral_ident_word4 |-> o_apb.prdata[7:4] == 4'h0 && o_apb.prdata[3:0] == 4'h0;
    endproperty
    a_peripheral_ident_word4_fields: assert property (p_peripheral_ident_word4_fields) // see [R07] see [R09]
        else $error("id word four fields not zero");

    property p_peripheral_ident_word4_zero;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        rd_done && hit_peripheral_ident_word4 |-> o_apb.prdata == 32'h0000_0000 && !o_apb.pslverr;
    endproperty
    a_peripheral_ident_word4_zero: assert property (p_peripheral_ident_word4_zero) // see [R08]
        else $error("id word four not zero");

    property p_read_only;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        captured ##1 i_apb.psel && i_apb.pwrite [*2]
            |-> $stable(entry_present_flag) && $stable(sysmem_present_flag);
    endproperty
    a_read_only: assert property (p_read_only) // see [R10]
        else $error("write changed a latched flag");

    property p_answer_timing;
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        setup_phase |=> o_apb.pready ##1 !o_apb.pready;
    endproperty
    a_answer_timing: assert property (p_answer_timing) // see [R10]
        else $error("pready not a single access cycle");

endmodule

// ### verification/drt_apb_adapter.sv
/*
 * drt_apb_adapter: apb master model of the debug adapter that walks the rom table.
 * assumes the slave answers on i_ref_clk; waits for pready are bounded at 16 cycles inside xfer.
 */
`timescale 1ns/1ps
module drt_apb_adapter (
    // clock
    input wire logic i_ref_clk,
    // apb master side
    input wire drt_pkg::drt_apb_rsp_t i_apb,
    output drt_pkg::drt_apb_req_t o_apb
);
    initial o_apb = '0;

    // =====================================================================
    // one transfer: setup, access until pready, then release
    // =====================================================================
    task automatic xfer(input logic wr, input logic [drt_pkg::ADDR_W-1:0] addr,
                        input logic [drt_pkg::DATA_W-1:0] wdata,
                        output logic [drt_pkg::DATA_W-1:0] rdata,
                        output logic err, output logic done);
        int n;
        done = 1'b0;
        rdata = '0;
        err = 1'b0;
        @(posedge i_ref_clk);
        o_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge i_ref_clk);
        o_apb.penable <= 1'b1;
        for (n = 0; n < 16 && !done; n++) begin
            @(posedge i_ref_clk);
            if (i_apb.pready === 1'b1) begin
                rdata = i_apb.prdata;
                err = i_apb.pslverr;
                done = 1'b1;
            end
        end
        // released lines show the inverse so stale values cannot pass
        o_apb <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~addr, pwdata: ~wdata};
    endtask
endmodule

// ### verification/debug_rom_table_tail_tb.sv
/*
 * debug_rom_table_tail_tb: reads and writes every word of the rom table tail
 * under both protection states. assumes one clock and the adapter model.
 */
`timescale 1ns/1ps
module debug_rom_table_tail_tb;
    localparam logic [19:0] OFFS = 20'habcde;
    logic i_ref_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_protected = 1'b0;
    drt_pkg::drt_apb_req_t req;
    drt_pkg::drt_apb_rsp_t rsp;
    int fails = 0;
    int checks_done = 0;
    logic [drt_pkg::ADDR_W-1:0] addr_v[4];
    logic [31:0] exp_v[4];

    always #4 i_ref_clk = ~i_ref_clk;

    drt_rom_tail #(.COMPONENT_OFFSET(OFFS)) drt_rom_tail_i (
        .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_protected(i_protected),
        .i_apb(req), .o_apb(rsp));
    drt_apb_adapter drt_apb_adapter_i (.i_ref_clk(i_ref_clk), .i_apb(rsp), .o_apb(req));

    // =====================================================================
    // helpers
    // =====================================================================
    task automatic op(input logic wr, input logic [drt_pkg::ADDR_W-1:0] a,
                      input logic [31:0] exp, input logic experr);
        logic [31:0] d;
        logic e;
        logic ok;
        drt_apb_adapter_i.xfer(wr, a, 32'hffff_ffff, d, e, ok);
        checks_done++;
        if (ok !== 1'b1 || d !== exp || e !== experr) begin
            fails++;
            $display("Error at %0t: addr %h got %h err %b", $time, a, d, e);
        end
    endtask

    task automatic do_reset(input logic prot);
        i_arst_n <= 1'b0;
        i_protected <= prot;
        repeat (16) @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        // flags are caught at the first edge after release
        repeat (2) @(posedge i_ref_clk);
        addr_v = '{drt_pkg::OFF_ROM_ENTRY_WORD, drt_pkg::OFF_ROM_TABLE_END_MARKER,
                   drt_pkg::OFF_ROM_MEMORY_TYPE, drt_pkg::OFF_PERIPHERAL_IDENT_WORD4};
        exp_v = '{{OFFS, 10'h000, 1'b1, prot}, 32'h0000_0000, {31'h0, ~prot}, 32'h0000_0000};
    endtask

    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // =====================================================================
    // tests
    // =====================================================================
    initial begin
        for (int p = 0; p < 2; p++) begin
            do_reset(p[0]);
            for (int i = 0; i < 4; i++) op(1'b0, addr_v[i], exp_v[i], 1'b0);
            // latched flags must ignore later protection changes
            i_protected <= ~p[0];
            for (int i = 0; i < 4; i++) op(1'b1, addr_v[i], 32'h0000_0000, 1'b0);
            for (int i = 0; i < 4; i++) op(1'b0, addr_v[i], exp_v[i], 1'b0);
            op(1'b0, drt_pkg::OFF_ROM_MEMORY_TYPE | 13'h0003, exp_v[2], 1'b0);
            op(1'b0, 13'h1ffc, 32'h0000_0000, 1'b1);
            $display("test protection state %0d done", p);
        end
        final_report();
    end

    initial begin
        #20000;
        fails++;
        final_report();
    end
endmodule
